// >>> inc/dsc_pkg.sv
// dsc_pkg: constants and types for the dual-slope conversion control block
// Functional notes
// - gate high repeats 8192-clock conversion cycles
// - phases run zeroing, integrate, de-integrate, clear
// - zeroing grounds inputs, charges reference, closes loop
// - integrate connects inputs for 2048 clocks
// - comparator sampled at integrate end gives sign
// - reference connected opposite to measured sign
// - de-integrate clocks counted into 12-bit latches
// - clear phase only after over range, max 1024
// - clear phase disconnects inputs, feeds comparator back
// - status rises when integrate begins
// - status falls half clock after latch, one master clock in rc mode
// - latched data frozen while status low
// - mode low: byte pins gate latched bytes
// - mode pulse sends two bytes then direct
// - mode held high sends bytes every cycle
// - gate low halts seven counts before integrate
// - crystal mode divides oscillator by 58
// - handshake turns byte enables into flag outputs
package dsc_pkg;
    // conversion frame, in conversion clocks
    localparam int CONV_CYCLE_CLKS = 8192;
    localparam int INTEG_CLKS = 2048;
    localparam int FULL_SCALE_CLKS = 4096;
    localparam int CLEAR_MAX_CLKS = 1024;
    localparam int HOLD_LEAD_CLKS = 7;
    localparam logic [12:0] INT_END = 13'(INTEG_CLKS);
    localparam logic [12:0] DEINT_END = 13'(INTEG_CLKS + FULL_SCALE_CLKS);
    localparam logic [12:0] CLEAR_END = 13'(INTEG_CLKS + FULL_SCALE_CLKS + CLEAR_MAX_CLKS);
    localparam logic [11:0] MAG_FULL = 12'(FULL_SCALE_CLKS - 1);
    // oscillator scaling, in master clocks
    localparam int OSC_DIV_XTAL = 58;
    localparam logic [4:0] HALF_XTAL = 5'(OSC_DIV_XTAL / 2);
    localparam logic [4:0] HALF_RC = 5'h01;
    // reset values
    localparam logic [6:0] PIN_SYNC_RST = 7'h70;
    localparam logic CTRL_RST = 1'b0;
    // register map
    localparam logic [7:0] ADR_CTRL = 8'h00;
    localparam logic [7:0] ADR_RESULT = 8'h04;
    localparam logic [7:0] ADR_STATE = 8'h08;
    // field positions
    localparam int CTRL_OSC_BIT = 0;
    localparam int RES_SIGN_BIT = 12;
    localparam int RES_OVER_BIT = 13;
    localparam int ST_STATUS_BIT = 0;
    localparam int ST_PHASE_LSB = 1;
    localparam int ST_HS_BIT = 3;
    typedef enum {PH_ZERO, PH_INTEG, PH_DEINT, PH_CLEAR} dsc_phase_t;
    typedef enum {HS_IDLE, HS_WAIT_HI, HS_LOAD_HI, HS_HOLD_HI,
                  HS_WAIT_LO, HS_LOAD_LO, HS_HOLD_LO} dsc_hs_t;
endpackage

// >>> hdl/dsc_conv_ctrl.sv
// dsc_conv_ctrl: dual-slope sequencer, result latches, output modes, wishbone regs
//
// Implementation choices: the address map and register access over Wishbone.
`timescale 1ns/10ps
module dsc_conv_ctrl import dsc_pkg::*; #(
    parameter int CYCLE_CLKS = CONV_CYCLE_CLKS
) (
    // clock and reset
    input wire logic mclk_i,
    input wire logic reset_i,
    // wishbone slave
    input wire logic wb_cyc_i,
    input wire logic wb_stb_i,
    input wire logic wb_we_i,
    input wire logic [7:0] wb_adr_i,
    input wire logic [3:0] wb_sel_i,
    input wire logic [31:0] wb_dat_i,
    output logic [31:0] wb_dat_o,
    output logic wb_ack_o,
    // control pins
    input wire logic run_gate_i,
    input wire logic mode_i,
    input wire logic send_i,
    input wire logic comparator_i,
    output logic status_o,
    // byte control pins, two-way
    input wire logic ce_load_i,
    output logic ce_load_o,
    output logic ce_load_oe_o,
    input wire logic high_byte_enable_i,
    output logic high_byte_enable_o,
    output logic high_byte_enable_oe_o,
    input wire logic low_byte_enable_i,
    output logic low_byte_enable_o,
    output logic low_byte_enable_oe_o,
    // result bytes
    output logic [7:0] low_byte_o,
    output logic low_byte_oe_o,
    output logic [5:0] high_byte_o,
    output logic high_byte_oe_o,
    // analog switch controls
    output logic zeroing_phase_o,
    output logic signal_connect_o,
    output logic reference_deintegrate_phase_o,
    output logic ref_polarity_o,
    output logic integrator_clear_phase_o,
    output logic ref_charge_o,
    output logic comp_feedback_o
);
    localparam logic [12:0] CYC_LAST = 13'(CYCLE_CLKS - 1);
    localparam logic [12:0] HOLD_POINT = 13'(CYCLE_CLKS - HOLD_LEAD_CLKS);
    localparam int HALF_DLY = OSC_DIV_XTAL / 2;

    logic [6:0] sync1_r, sync1_nxt, sync2_r, sync2_nxt;
    logic mode_d_r, mode_d_nxt;
    logic gate_s, mode_s, send_s, comp_s, ce_s, high_byte_enable_s, low_byte_enable_s, mode_rise;
    logic ack_r, ack_nxt, ctrl_r, ctrl_nxt, osc_rc;
    logic [31:0] dat_r, dat_nxt;
    logic [5:0] div_r, div_nxt;
    logic tick, latch_evt;
    logic [12:0] cyc_r, cyc_nxt;
    dsc_phase_t phase_r, phase_nxt;
    logic sign_r, sign_nxt, crossed_r, crossed_nxt, over_r, over_nxt;
    logic status_r, status_nxt;
    logic [4:0] fall_r, fall_nxt;
    logic [11:0] de_cnt_r, de_cnt_nxt, mag_r, mag_nxt;
    logic rsign_r, rsign_nxt, rover_r, rover_nxt;
    dsc_hs_t hs_r, hs_nxt;
    logic hi_hs, lo_hs, pin_oe_r, pin_oe_nxt, ce_r, ce_nxt;
    logic high_byte_enable_r, high_byte_enable_nxt, low_byte_enable_r, low_byte_enable_nxt, hi_oe_r, hi_oe_nxt, lo_oe_r, lo_oe_nxt;

    function automatic dsc_phase_t phase_at(input logic [12:0] c, input logic ovr);
        if (c < INT_END) return PH_INTEG;
        if (c < DEINT_END) return PH_DEINT;
        if (ovr && c < CLEAR_END) return PH_CLEAR;
        return PH_ZERO;
    endfunction

    // two-flop synchronisers; edge detect reads only the second stage
    always_comb begin
        sync1_nxt = {low_byte_enable_i, high_byte_enable_i, ce_load_i, comparator_i,
                     send_i, mode_i, run_gate_i};
        sync2_nxt = sync1_r;
        mode_d_nxt = sync2_r[1];
    end
    always_ff @(posedge mclk_i or posedge reset_i) begin
        if (reset_i) begin
            sync1_r <= PIN_SYNC_RST;
            sync2_r <= PIN_SYNC_RST;
            mode_d_r <= 1'b0;
        end else begin
            sync1_r <= sync1_nxt;
            sync2_r <= sync2_nxt;
            mode_d_r <= mode_d_nxt;
        end
    end
    assign {low_byte_enable_s, high_byte_enable_s, ce_s, comp_s, send_s, mode_s, gate_s} = sync2_r;
    assign mode_rise = mode_s & ~mode_d_r;

    // wishbone: ack one cycle after the strobe, dropped the cycle after
    always_comb begin
        ack_nxt = wb_cyc_i & wb_stb_i & ~ack_r;
        ctrl_nxt = ctrl_r;
        dat_nxt = dat_r;
        if (ack_nxt) begin
            dat_nxt = 32'h0000_0000;
            case (wb_adr_i)
                ADR_CTRL: begin
                    dat_nxt[CTRL_OSC_BIT] = ctrl_r;
                    if (wb_we_i && wb_sel_i[0]) ctrl_nxt = wb_dat_i[CTRL_OSC_BIT];
                end
                ADR_RESULT: begin
                    dat_nxt[11:0] = mag_r;
                    dat_nxt[RES_SIGN_BIT] = rsign_r;
                    dat_nxt[RES_OVER_BIT] = rover_r;
                end
                ADR_STATE: begin
                    dat_nxt[ST_STATUS_BIT] = status_r;
                    dat_nxt[ST_PHASE_LSB +: 2] = 2'(phase_r);
                    dat_nxt[ST_HS_BIT] = (hs_r != HS_IDLE);
                end
                default: dat_nxt = 32'h0000_0000; // unmapped reads zero, writes dropped
            endcase
        end
    end
    always_ff @(posedge mclk_i or posedge reset_i) begin
        if (reset_i) begin
            ack_r <= 1'b0;
            ctrl_r <= CTRL_RST;
            dat_r <= 32'h0000_0000;
        end else begin
            ack_r <= ack_nxt;
            ctrl_r <= ctrl_nxt;
            dat_r <= dat_nxt;
        end
    end
    assign wb_ack_o = ack_r;
    assign wb_dat_o = dat_r;
    assign osc_rc = ctrl_r;

    // conversion clock tick: every master clock in rc mode, else one in 58
    assign tick = osc_rc | (div_r == 6'(OSC_DIV_XTAL - 1));

    // sequencer, de-integrate counter and result latches
    always_comb begin
        div_nxt = (osc_rc || tick) ? 6'h00 : div_r + 6'h01;
        cyc_nxt = cyc_r;
        phase_nxt = phase_r;
        sign_nxt = sign_r;
        crossed_nxt = crossed_r;
        over_nxt = over_r;
        de_cnt_nxt = de_cnt_r;
        status_nxt = status_r;
        fall_nxt = fall_r;
        mag_nxt = mag_r;
        rsign_nxt = rsign_r;
        rover_nxt = rover_r;
        latch_evt = 1'b0;
        // rc mode has no half period to wait, so one master clock is used
        if (fall_r != 5'h00) begin
            fall_nxt = fall_r - 5'h01;
            if (fall_r == 5'h01) status_nxt = 1'b0;
        end
        if (tick) begin
            if (!(cyc_r == HOLD_POINT && !gate_s)) begin
                cyc_nxt = (cyc_r == CYC_LAST) ? 13'h0000 : cyc_r + 13'h0001;
            end
            if (phase_r == PH_DEINT && !crossed_r) begin
                if (comp_s != sign_r || de_cnt_r == MAG_FULL) begin
                    latch_evt = 1'b1;
                    crossed_nxt = 1'b1;
                    over_nxt = (comp_s == sign_r);
                end else begin
                    de_cnt_nxt = de_cnt_r + 12'h001;
                end
            end
            if (phase_r == PH_INTEG && cyc_nxt == INT_END) begin
                sign_nxt = comp_s;
                de_cnt_nxt = 12'h000;
                crossed_nxt = 1'b0;
                over_nxt = 1'b0;
            end
            phase_nxt = phase_at(cyc_nxt, over_nxt);
            if (phase_r != PH_INTEG && phase_nxt == PH_INTEG) status_nxt = 1'b1;
        end
        // latches frozen while a handshake output cycle runs
        if (latch_evt) begin
            fall_nxt = osc_rc ? HALF_RC : HALF_XTAL;
            if (hs_r == HS_IDLE) begin
                mag_nxt = (comp_s != sign_r) ? de_cnt_r : MAG_FULL;
                rsign_nxt = sign_r;
                rover_nxt = over_nxt;
            end
        end
    end
    always_ff @(posedge mclk_i or posedge reset_i) begin
        if (reset_i) begin
            div_r <= 6'h00;
            cyc_r <= CLEAR_END;
            phase_r <= PH_ZERO;
            sign_r <= 1'b0;
            crossed_r <= 1'b0;
            over_r <= 1'b0;
            de_cnt_r <= 12'h000;
            status_r <= 1'b0;
            fall_r <= 5'h00;
            mag_r <= 12'h000;
            rsign_r <= 1'b0;
            rover_r <= 1'b0;
        end else begin
            div_r <= div_nxt;
            cyc_r <= cyc_nxt;
            phase_r <= phase_nxt;
            sign_r <= sign_nxt;
            crossed_r <= crossed_nxt;
            over_r <= over_nxt;
            de_cnt_r <= de_cnt_nxt;
            status_r <= status_nxt;
            fall_r <= fall_nxt;
            mag_r <= mag_nxt;
            rsign_r <= rsign_nxt;
            rover_r <= rover_nxt;
        end
    end

    // analog switch decode of the registered phase and sign
    assign zeroing_phase_o = (phase_r == PH_ZERO);
    assign signal_connect_o = (phase_r == PH_INTEG);
    assign reference_deintegrate_phase_o = (phase_r == PH_DEINT);
    assign ref_polarity_o = ~sign_r;
    assign integrator_clear_phase_o = (phase_r == PH_CLEAR);
    assign ref_charge_o = (phase_r == PH_ZERO) | (phase_r == PH_CLEAR);
    assign comp_feedback_o = (phase_r == PH_CLEAR);
    assign status_o = status_r;

    // handshake output cycle and byte pin control
    always_comb begin
        hs_nxt = hs_r;
        if (hs_r == HS_IDLE) begin
            if (mode_rise || (latch_evt && mode_s)) hs_nxt = HS_WAIT_HI;
        end else if (tick) begin
            case (hs_r)
                HS_WAIT_HI: if (send_s) hs_nxt = HS_LOAD_HI;
                HS_LOAD_HI: hs_nxt = HS_HOLD_HI;
                HS_HOLD_HI: hs_nxt = HS_WAIT_LO;
                HS_WAIT_LO: if (send_s) hs_nxt = HS_LOAD_LO;
                HS_LOAD_LO: hs_nxt = HS_HOLD_LO;
                default: hs_nxt = HS_IDLE;
            endcase
        end
        hi_hs = (hs_nxt == HS_LOAD_HI) || (hs_nxt == HS_HOLD_HI);
        lo_hs = (hs_nxt == HS_LOAD_LO) || (hs_nxt == HS_HOLD_LO);
        pin_oe_nxt = (hs_nxt != HS_IDLE) || mode_s;
        ce_nxt = !((hs_nxt == HS_LOAD_HI) || (hs_nxt == HS_LOAD_LO));
        high_byte_enable_nxt = !hi_hs;
        low_byte_enable_nxt = !lo_hs;
        hi_oe_nxt = hi_hs || (!pin_oe_nxt && !ce_s && !high_byte_enable_s);
        lo_oe_nxt = lo_hs || (!pin_oe_nxt && !ce_s && !low_byte_enable_s);
    end
    always_ff @(posedge mclk_i or posedge reset_i) begin
        if (reset_i) begin
            hs_r <= HS_IDLE;
            pin_oe_r <= 1'b0;
            ce_r <= 1'b1;
            high_byte_enable_r <= 1'b1;
            low_byte_enable_r <= 1'b1;
            hi_oe_r <= 1'b0;
            lo_oe_r <= 1'b0;
        end else begin
            hs_r <= hs_nxt;
            pin_oe_r <= pin_oe_nxt;
            ce_r <= ce_nxt;
            high_byte_enable_r <= high_byte_enable_nxt;
            low_byte_enable_r <= low_byte_enable_nxt;
            hi_oe_r <= hi_oe_nxt;
            lo_oe_r <= lo_oe_nxt;
        end
    end
    assign ce_load_o = ce_r;
    assign high_byte_enable_o = high_byte_enable_r;
    assign low_byte_enable_o = low_byte_enable_r;
    assign ce_load_oe_o = pin_oe_r;
    assign high_byte_enable_oe_o = pin_oe_r;
    assign low_byte_enable_oe_o = pin_oe_r;
    assign low_byte_o = mag_r[7:0];
    assign high_byte_o = {rover_r, rsign_r, mag_r[11:8]};
    assign high_byte_oe_o = hi_oe_r;
    assign low_byte_oe_o = lo_oe_r;

    // checks
    default clocking cb @(posedge mclk_i); endclocking
    default disable iff (reset_i);
    sequence s_fall_xtal;
        ##HALF_DLY status_r ##1 !status_r;
    endsequence
    sequence s_fall_rc;
        ##1 status_r ##1 !status_r;
    endsequence
    a_cycle_wrap: assert property (tick && cyc_r == CYC_LAST |=> cyc_r == 13'h0000
        && phase_r == PH_INTEG && status_r) else $error("cycle did not wrap to integrate");
    a_phase_order: assert property (phase_r != $past(phase_r) |->
        ($past(phase_r) == PH_ZERO && phase_r == PH_INTEG)
        || ($past(phase_r) == PH_INTEG && phase_r == PH_DEINT)
        || ($past(phase_r) == PH_DEINT && phase_r != PH_INTEG)
        || ($past(phase_r) == PH_CLEAR && phase_r == PH_ZERO)) else $error("bad phase order");
    a_zero_switches: assert property (zeroing_phase_o |-> ref_charge_o
        && !signal_connect_o && !comp_feedback_o) else $error("zeroing switches wrong");
    a_integ_window: assert property ((phase_r == PH_INTEG) == (cyc_r < INT_END))
        else $error("integrate window not 2048 clocks");
    a_sign_sample: assert property (phase_r == PH_DEINT && $past(phase_r) == PH_INTEG
        |-> sign_r == $past(comp_s)) else $error("sign not sampled at integrate end");
    a_ref_polarity: assert property (reference_deintegrate_phase_o
        |-> ref_polarity_o == !sign_r && !signal_connect_o) else $error("reference polarity");
    a_result_count: assert property (latch_evt && hs_r == HS_IDLE && !over_nxt
        |=> mag_r == $past(de_cnt_r)) else $error("result count not latched");
    a_clear_window: assert property (integrator_clear_phase_o |-> over_r
        && cyc_r >= DEINT_END && cyc_r < CLEAR_END && !signal_connect_o)
        else $error("clear phase outside over range window");
    a_status_rise: assert property ($rose(status_r) |-> phase_r == PH_INTEG
        && cyc_r == 13'h0000) else $error("status rose outside integrate start");
    a_status_fall_xtal: assert property (latch_evt && !osc_rc |-> s_fall_xtal)
        else $error("status fall not half period after latch");
    a_status_fall_rc: assert property (latch_evt && osc_rc |-> s_fall_rc)
        else $error("status fall late in rc mode");
    a_data_stable: assert property (!status_r && $past(status_r) == 1'b0
        |-> $stable(mag_r) && $stable(rsign_r) && $stable(rover_r)) else $error("data moved");
    a_direct_inputs: assert property (hs_r == HS_IDLE && $past(mode_s) == 1'b0
        |-> !ce_load_oe_o) else $error("byte pins driven in direct mode");
    a_mode_entry: assert property (latch_evt && mode_s && hs_r == HS_IDLE
        |=> hs_r == HS_WAIT_HI) else $error("no handshake after conversion");
    a_hold_point: assert property (tick && cyc_r == HOLD_POINT && !gate_s
        |=> cyc_r == HOLD_POINT && zeroing_phase_o) else $error("did not hold in zeroing");
    a_xtal_divider: assert property (tick && !osc_rc && $past(osc_rc) == 1'b0
        |-> $past(div_r) == 6'(OSC_DIV_XTAL - 2)) else $error("crystal divider not 58");
    a_hi_byte_flag: assert property (hs_r == HS_LOAD_HI |-> !ce_load_o
        && !high_byte_enable_o && low_byte_enable_o && high_byte_oe_o && !low_byte_oe_o)
        else $error("high byte flags wrong");
    a_over_full: assert property (rover_r |-> mag_r == MAG_FULL)
        else $error("over range without full count");
endmodule // dsc_conv_ctrl

// >>> testbench/dsc_uart_model.sv
// dsc_uart_model: byte receiver standing on the handshake side of the converter
`timescale 1ns/10ps
module dsc_uart_model (
    // clock and stall control
    input wire logic mclk_i,
    input wire logic slow_i,
    // handshake pins as seen on the wires, active low
    input wire logic ce_load_n_i,
    input wire logic hb_flag_n_i,
    input wire logic lb_flag_n_i,
    // data lines with their drive enables
    input wire logic [5:0] high_byte_i,
    input wire logic high_oe_i,
    input wire logic [7:0] low_byte_i,
    input wire logic low_oe_i,
    // receiver side
    output logic send_o,
    output logic [7:0] rx_hi_o,
    output logic [7:0] rx_lo_o,
    output logic [7:0] rx_cnt_o
);
    initial begin
        send_o = 1'b1;
        rx_hi_o = 8'h00;
        rx_lo_o = 8'h00;
        rx_cnt_o = 8'h00;
    end
    // ready only when a byte can be taken; a busy receiver stalls at random
    always @(posedge mclk_i) begin
        send_o <= slow_i ? 1'($urandom % 2) : 1'b1;
    end
    // load strobe low marks a byte; undriven data reads as a wrong pattern
    always @(posedge mclk_i) begin
        if (ce_load_n_i === 1'b0) begin
            rx_cnt_o <= rx_cnt_o + 8'h01;
            if (hb_flag_n_i === 1'b0) rx_hi_o <= high_oe_i ? {2'b00, high_byte_i} : 8'hEE;
            else if (lb_flag_n_i === 1'b0) rx_lo_o <= low_oe_i ? low_byte_i : 8'hEE;
        end
    end
endmodule // dsc_uart_model

// >>> testbench/dsc_conv_ctrl_test.sv
// dsc_conv_ctrl_test: self-checking bench for the dual-slope conversion control
`timescale 1ns/10ps
module dsc_conv_ctrl_test import dsc_pkg::*; ;
    // design pins, all driven from time zero
    logic mclk_i = 1'b0, reset_i = 1'b1;
    logic wb_cyc_i = 1'b0, wb_stb_i = 1'b0, wb_we_i = 1'b0, wb_ack_o;
    logic [7:0] wb_adr_i = 8'h00;
    logic [31:0] wb_dat_i = 32'h0, wb_dat_o;
    logic run_gate_i = 1'b1, mode_i = 1'b0, comparator_i = 1'b0, send_i, status_o;
    logic ce_load_o, ce_load_oe_o, high_byte_enable_o, high_byte_enable_oe_o;
    logic low_byte_enable_o, low_byte_enable_oe_o, low_byte_oe_o, high_byte_oe_o;
    logic [7:0] low_byte_o;
    logic [5:0] high_byte_o;
    logic zeroing_phase_o, signal_connect_o, reference_deintegrate_phase_o, ref_polarity_o;
    logic integrator_clear_phase_o, ref_charge_o, comp_feedback_o;
    // byte pins: bench drives them in direct mode, pull-ups win when released
    logic drv_ce = 1'b1, drv_hb = 1'b1, drv_lb = 1'b1, slow = 1'b0, sign_sel = 1'b1;
    wire ce_w = ce_load_oe_o ? ce_load_o : drv_ce;
    wire hb_w = high_byte_enable_oe_o ? high_byte_enable_o : drv_hb;
    wire lb_w = low_byte_enable_oe_o ? low_byte_enable_o : drv_lb;
    logic [7:0] rx_hi, rx_lo, rx_cnt, rx_target = 8'h00;
    int err_count = 0, checks = 0, cyc_n = 0, deint_n = 0, clr_n = 0;
    int flip_at = 5000, hi_e = 0, lo_e = 0, tol = 0;

    dsc_conv_ctrl i_dsc_conv_ctrl (
        .mclk_i(mclk_i), .reset_i(reset_i), .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i),
        .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i), .wb_sel_i(4'hF), .wb_dat_i(wb_dat_i),
        .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o), .run_gate_i(run_gate_i), .mode_i(mode_i),
        .send_i(send_i), .comparator_i(comparator_i), .status_o(status_o),
        .ce_load_i(ce_w), .ce_load_o(ce_load_o), .ce_load_oe_o(ce_load_oe_o),
        .high_byte_enable_i(hb_w), .high_byte_enable_o(high_byte_enable_o),
        .high_byte_enable_oe_o(high_byte_enable_oe_o), .low_byte_enable_i(lb_w),
        .low_byte_enable_o(low_byte_enable_o), .low_byte_enable_oe_o(low_byte_enable_oe_o),
        .low_byte_o(low_byte_o), .low_byte_oe_o(low_byte_oe_o), .high_byte_o(high_byte_o),
        .high_byte_oe_o(high_byte_oe_o), .zeroing_phase_o(zeroing_phase_o),
        .signal_connect_o(signal_connect_o),
        .reference_deintegrate_phase_o(reference_deintegrate_phase_o),
        .ref_polarity_o(ref_polarity_o), .integrator_clear_phase_o(integrator_clear_phase_o),
        .ref_charge_o(ref_charge_o), .comp_feedback_o(comp_feedback_o));

    dsc_uart_model i_dsc_uart_model (
        .mclk_i(mclk_i), .slow_i(slow), .ce_load_n_i(ce_w), .hb_flag_n_i(hb_w),
        .lb_flag_n_i(lb_w), .high_byte_i(high_byte_o), .high_oe_i(high_byte_oe_o),
        .low_byte_i(low_byte_o), .low_oe_i(low_byte_oe_o), .send_o(send_i),
        .rx_hi_o(rx_hi), .rx_lo_o(rx_lo), .rx_cnt_o(rx_cnt));

    initial forever #50 mclk_i = ~mclk_i;

    // integrator stand-in: holds the chosen sign, crosses zero after flip_at clocks
    always @(posedge mclk_i) begin
        cyc_n <= cyc_n + 1;
        deint_n <= reference_deintegrate_phase_o ? deint_n + 1 : 0;
        if (integrator_clear_phase_o) clr_n <= clr_n + 1;
        if (signal_connect_o) comparator_i <= sign_sel;
        else if (reference_deintegrate_phase_o) comparator_i <= sign_sel ^ (deint_n >= flip_at);
        else comparator_i <= 1'($urandom % 2);
    end

    // range compare; synchroniser latency makes the exact count a few clocks loose
    task automatic chk(input logic [31:0] got, input logic [31:0] lo, input logic [31:0] hi);
        checks++;
        if ((got >= lo && got <= hi) !== 1'b1) begin
            err_count++;
            $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, lo);
        end
    endtask

    task automatic test_done();
        $display("checks=%0d err_count=%0d", checks, err_count);
        if (err_count == 0 && checks > 0) begin
            $display("verification passed");
        end else begin
            $display("verification failed");
        end
        $finish;
    endtask

    task automatic give_up(input int k);
        err_count++;
        $display("CHECK FAILED t=%0t got=%h exp=%h", $time, k, 32'h0);
        test_done();
    endtask

    function automatic logic sig(input int k);
        case (k)
            0: return status_o;
            1: return reference_deintegrate_phase_o;
            2: return integrator_clear_phase_o;
            3: return zeroing_phase_o;
            default: return logic'(rx_cnt == rx_target);
        endcase
    endfunction

    // bounded wait for a level, n counts the edges passed
    task automatic wait_for(input int k, input logic v, input int lim, output int n);
        n = 0;
        while (sig(k) !== v) begin
            @(posedge mclk_i);
            n++;
            if (n > lim) give_up(k);
        end
    endtask

    // classic single wishbone cycle, held until ack is sampled high
    task automatic wb(input logic w, input logic [7:0] a, input logic [31:0] d,
                      output logic [31:0] q);
        int n;
        n = 0;
        @(posedge mclk_i);
        {wb_cyc_i, wb_stb_i, wb_we_i, wb_adr_i, wb_dat_i} <= {2'b11, w, a, d};
        do begin
            @(posedge mclk_i);
            n++;
        end while (wb_ack_o !== 1'b1 && n < 20);
        q = wb_dat_o;
        {wb_cyc_i, wb_stb_i} <= 2'b00;
        if (wb_ack_o !== 1'b1) give_up(99);
    endtask

    task automatic chk_res();
        logic [31:0] q;
        wb(1'b0, ADR_RESULT, 32'h0, q);
        chk(32'(q[13:8]), hi_e, hi_e);
        chk(32'(q[7:0]), lo_e, lo_e + tol);
    endtask

    initial begin
        int n, t_prev;
        logic [31:0] q;
        void'($urandom(32'hB01A7370));
        // outputs are only settled after the first reset edge has been applied
        repeat (6) @(posedge mclk_i);
        chk({status_o, zeroing_phase_o, ref_charge_o, ref_polarity_o, low_byte_oe_o,
             high_byte_oe_o, ce_load_oe_o, ce_load_o}, 8'h71, 8'h71);
        reset_i <= 1'b0;
        wb(1'b0, ADR_CTRL, 32'h0, q);
        chk(q, 32'h0, 32'h0);
        wb(1'b1, ADR_CTRL, 32'h1, q);
        wb(1'b1, ADR_RESULT, 32'hFFFF, q);
        wb(1'b0, 8'h0C, 32'h0, q);
        chk(q, 32'h0, 32'h0);
        wb(1'b0, ADR_CTRL, 32'h0, q);
        chk(q, 32'h1, 32'h1);
        t_prev = 0;
        // frames: plain, over range, mode held with stalls, mode pulse
        for (int f = 0; f < 4; f++) begin
            sign_sel = (f == 0 || f == 3);
            flip_at = (f == 1) ? 5000 : 256 * (1 + int'($urandom % 11)) + int'($urandom % 200);
            hi_e = ((f == 1) ? 8'h2F : flip_at / 256) + (sign_sel ? 16 : 0);
            lo_e = (f == 1) ? 255 : flip_at % 256;
            tol = (f == 1) ? 0 : 6;
            // mode rise in frame 2 first resends the old result: four bytes in all
            rx_target = rx_cnt + ((f == 2) ? 8'h04 : 8'h02);
            if (f == 2) begin
                mode_i <= 1'b1;
                slow <= 1'b1;
            end
            wait_for(0, 1'b1, 9000, n);
            if (f > 0) chk(cyc_n - t_prev, CONV_CYCLE_CLKS, CONV_CYCLE_CLKS);
            t_prev = cyc_n;
            chk({signal_connect_o, zeroing_phase_o}, 2'b10, 2'b10);
            wait_for(1, 1'b1, 2100, n);
            chk(n, INTEG_CLKS, INTEG_CLKS);
            chk(ref_polarity_o, !sign_sel, !sign_sel);
            wait_for(0, 1'b0, 4200, n);
            chk_res();
            if (f == 0) begin
                drv_ce <= 1'b0;
                drv_hb <= 1'b0;
                repeat (6) @(posedge mclk_i);
                chk({high_byte_oe_o, low_byte_oe_o}, 2'b10, 2'b10);
                chk(32'(high_byte_o), hi_e, hi_e);
                drv_hb <= 1'b1;
                drv_lb <= 1'b0;
                repeat (6) @(posedge mclk_i);
                chk({high_byte_oe_o, low_byte_oe_o}, 2'b01, 2'b01);
                chk(32'(low_byte_o), lo_e, lo_e + tol);
                drv_ce <= 1'b1;
                drv_lb <= 1'b1;
            end
            if (f == 1) begin
                wait_for(2, 1'b1, 10, n);
                chk({comp_feedback_o, ref_charge_o, signal_connect_o}, 3'b110, 3'b110);
            end
            if (f >= 2) begin
                if (f == 3) begin
                    rx_target = rx_cnt + 8'h02;
                    mode_i <= 1'b1;
                    repeat (3) @(posedge mclk_i);
                    mode_i <= 1'b0;
                    @(posedge mclk_i); // pin enables register one edge after the sync
                end
                chk(ce_load_oe_o, 1'b1, 1'b1);
                wait_for(4, 1'b1, 3000, n);
                chk(rx_hi, hi_e, hi_e);
                chk(rx_lo, lo_e, lo_e + tol);
                mode_i <= 1'b0;
                slow <= 1'b0;
                repeat (6) @(posedge mclk_i);
                chk(ce_load_oe_o, 1'b0, 1'b0);
            end
            wait_for(3, 1'b1, 7000, n);
            chk({reference_deintegrate_phase_o, integrator_clear_phase_o, ref_charge_o,
                 signal_connect_o}, 4'h2, 4'h2);
            chk(clr_n, (f > 0), (f > 0) ? CLEAR_MAX_CLKS : 0);
            chk_res();
        end
        // gate low: the converter parks in zeroing until the gate returns
        run_gate_i <= 1'b0;
        repeat (9) begin
            repeat (1000) @(posedge mclk_i);
            chk({status_o, zeroing_phase_o}, 2'b01, 2'b01);
        end
        run_gate_i <= 1'b1;
        wait_for(0, 1'b1, 40, n);
        chk(n, HOLD_LEAD_CLKS, HOLD_LEAD_CLKS + 4);
        // second hold, released in crystal mode: seven ticks of 58 clocks each
        run_gate_i <= 1'b0;
        repeat (8300) @(posedge mclk_i);
        chk({status_o, zeroing_phase_o}, 2'b01, 2'b01);
        wb(1'b1, ADR_CTRL, 32'h0, q);
        run_gate_i <= 1'b1;
        wait_for(0, 1'b1, 500, n);
        t_prev = HOLD_LEAD_CLKS * OSC_DIV_XTAL;
        chk(n, t_prev - OSC_DIV_XTAL + 4, t_prev + 3);
        test_done();
    end
endmodule // dsc_conv_ctrl_test
